/* File: verilog/arir_core.sv */
/*
 auto-reclose sequencer with indication and latched-output clearing, wishbone slave.
 assumes breaker contact and start inputs are asynchronous pins; one 100 MHz clock.
*/
// Contract
// - with the signalling-reset policy set, a reclose confirmed closed clears lamps, display, flags and latched outputs.
// - under that policy only a final trip keeps indications; a reclose that stays closed clears them.
// - the general reset clears indications and latched outputs at any time regardless of policy; here a new trip latched in the same cycle wins.
// - lamp policy 0 clears only on operator reset, 1 also clears on start of a trip-assigned element.
// - output policy has the same two choices for latched output relays.
// - with clear-on-start only the latest trip stays indicated.
// - a minimum drop-off delay is settable, separately for phase and neutral, optionally inverse-time; here the inverse-curve bit is unused.
// - the next reclose cycle is blocked while the drop-off delay still runs.
// - a new cycle starts only after both dead time and protection reset delay expire.
// - the close command goes out at the later of dead time end and drop-off end.
// - delayed reclosing extends the dead time by an energy check window and locks out if energy stays low.
// - the reclaim timer may be held while protection start signals are active.
// - dead and drop-off timing start on breaker trip, from contact drop or protection reset by configuration.
// - the reclaim timer starts on breaker close and resets the sequence at expiry if no trip follows.
`timescale 1ns/1ns
`include "arir_params.svh"
module arir_core #(
    parameter int TICK_CYCLES = `ARIR_TICK_CYCLES
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [5:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic [31:0]      o_wb_dat,
    output logic             o_wb_ack,
    input  wire logic        i_breaker_closed_contact,
    input  wire logic        i_trip,
    input  wire logic        i_start_phase,
    input  wire logic        i_start_neutral,
    input  wire logic        i_prot_reset,
    input  wire logic        i_energy_ok,
    input  wire logic        i_new_trip_latch,
    input  wire logic        i_operator_reset,
    output logic             o_close_cmd,
    output logic [3:0]       o_indication,
    output logic             o_latched_output,
    output logic             o_in_progress,
    output logic             o_lockout,
    output logic             o_success
);
    typedef struct packed {
        logic [1:0]           contact_s;
        logic [1:0]           trip_s;
        logic [1:0]           sph_s;
        logic [1:0]           sne_s;
        logic [1:0]           prst_s;
        logic [1:0]           energy_s;
        logic [1:0]           latch_s;
        logic [1:0]           oper_s;
        logic                 contact_d;
        logic                 prst_d;
        logic                 start_d;
        logic                 neutral_cycle;
        logic [7:0]           ctrl;
        logic [15:0]          dead;
        logic [15:0]          drop_ph;
        logic [15:0]          drop_ne;
        logic [15:0]          reclaim;
        logic [15:0]          energy_win;
        arir_pkg::arir_state_t fsm;
        logic [15:0]          t_dead;
        logic [15:0]          t_drop;
        logic [15:0]          t_rc;
        logic [15:0]          t_en;
        logic                 dead_done;
        logic                 drop_done;
        logic [2:0]           shot;
        logic [15:0]          reclose_cnt;
        logic                 close_cmd;
        logic                 clear_pend;
        logic [3:0]           ind;
        logic                 lout;
        logic                 success;
        logic                 ack;
        logic [31:0]          rdat;
    } arir_core_st_t;

    arir_core_st_t st;
    arir_core_st_t next_st;
    logic          tick;

    arir_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .o_tick (tick)
    );

    function automatic logic [15:0] arir_dec(input logic [15:0] v, input logic en);
        arir_dec = (en && v != 16'h0) ? v - 16'h1 : v;
    endfunction : arir_dec

    function automatic logic [15:0] arir_wr(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] sel);
        arir_wr = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction : arir_wr

    function automatic logic arir_cmd_hit(input logic we, input logic [5:0] adr,
                                          input logic [3:0] sel, input logic bit_v);
        arir_cmd_hit = we && adr[5:2] == `ARIR_REG_CMD && sel[0] && bit_v;
    endfunction : arir_cmd_hit

    logic contact;
    logic trip;
    logic starts;
    logic prst;
    logic energy;
    logic new_trip;
    logic oper;
    logic bus_req;
    logic bus_wr;
    logic tripped;
    logic gen_reset;
    logic lock_clr;

    always_comb begin
        contact  = st.contact_s[1];
        trip     = st.trip_s[1];
        starts   = st.sph_s[1] | st.sne_s[1];
        prst     = st.prst_s[1];
        energy   = st.energy_s[1];
        new_trip = st.latch_s[1];
        oper     = st.oper_s[1];
        bus_req  = i_wb_cyc & i_wb_stb & ~st.ack;
        bus_wr   = bus_req & i_wb_we;
        gen_reset = oper | arir_cmd_hit(bus_wr, i_wb_adr, i_wb_sel, i_wb_dat[`ARIR_CMD_GENRESET]);
        lock_clr = arir_cmd_hit(bus_wr, i_wb_adr, i_wb_sel, i_wb_dat[`ARIR_CMD_LOCKCLR]);
        // breaker open edge or protection reset edge by configuration
        tripped = st.ctrl[`ARIR_CTRL_STARTSRC] ? (st.contact_d & ~contact)
                                               : (prst & ~st.prst_d);
    end

    always_comb begin
        next_st = st;
        // two flops per pin; only the second one feeds logic
        next_st.contact_s = {st.contact_s[0], i_breaker_closed_contact};
        next_st.trip_s    = {st.trip_s[0], i_trip};
        next_st.sph_s     = {st.sph_s[0], i_start_phase};
        next_st.sne_s     = {st.sne_s[0], i_start_neutral};
        next_st.prst_s    = {st.prst_s[0], i_prot_reset};
        next_st.energy_s  = {st.energy_s[0], i_energy_ok};
        next_st.latch_s   = {st.latch_s[0], i_new_trip_latch};
        next_st.oper_s    = {st.oper_s[0], i_operator_reset};
        next_st.contact_d = contact;
        next_st.prst_d    = prst;
        next_st.start_d   = starts;
        next_st.close_cmd = 1'b0;
        next_st.clear_pend = 1'b0;

        // new trip sets indication and latched output
        if (new_trip) begin
            next_st.ind  = 4'hF;
            next_st.lout = 1'b1;
            next_st.success = 1'b0;
        end
        if (st.sne_s[1]) begin
            next_st.neutral_cycle = 1'b1;
        end else if (st.sph_s[1]) begin
            next_st.neutral_cycle = 1'b0;
        end
        // rising start of a trip element drops the older trip's signalling
        if (starts & ~st.start_d & ~new_trip) begin
            if (st.ctrl[`ARIR_CTRL_LAMPPOL]) begin
                next_st.ind = 4'h0;
            end
            if (st.ctrl[`ARIR_CTRL_OUTPOL]) begin
                next_st.lout = 1'b0;
            end
        end
        // clearing one cycle after confirmation; lockout and counter untouched
        if (st.clear_pend && !new_trip) begin
            next_st.ind  = 4'h0;
            next_st.lout = 1'b0;
        end
        if (gen_reset && !new_trip) begin
            next_st.ind  = 4'h0;
            next_st.lout = 1'b0;
        end

        // timers count whole ticks; a reload further down wins over a tick
        if (tick) begin
            next_st.t_dead = arir_dec(st.t_dead, 1'b1);
            next_st.t_drop = arir_dec(st.t_drop, 1'b1);
            next_st.t_en   = arir_dec(st.t_en, 1'b1);
            next_st.t_rc = arir_dec(st.t_rc,
                                    ~(st.ctrl[`ARIR_CTRL_RCBLOCK] & starts));
        end

        case (st.fsm)
            arir_pkg::ARIR_IDLE: begin
                if (st.ctrl[`ARIR_CTRL_ENABLE] && tripped) begin
                    next_st.fsm = arir_pkg::ARIR_DEAD;
                    next_st.shot = 3'h1;
                end
            end
            arir_pkg::ARIR_DEAD: begin
                if (st.t_dead == 16'h0) begin
                    next_st.dead_done = 1'b1;
                end
                if (st.t_drop == 16'h0 && prst) begin
                    next_st.drop_done = 1'b1;
                end
                // check window opens only once the dead time has run out
                if (!st.ctrl[`ARIR_CTRL_DELAYED] || energy || !st.dead_done) begin
                    next_st.t_en = st.energy_win;
                end
                if (st.ctrl[`ARIR_CTRL_DELAYED] && !energy && st.dead_done) begin
                    if (st.t_en == 16'h0) begin
                        next_st.fsm = arir_pkg::ARIR_LOCKOUT;
                    end
                end else if (st.dead_done && st.drop_done) begin
                    // later of dead and drop-off ends closes; drop-off blocks earlier close
                    next_st.close_cmd = 1'b1;
                    next_st.fsm = arir_pkg::ARIR_CLOSE;
                end
            end
            arir_pkg::ARIR_CLOSE: begin
                if (contact) begin
                    next_st.fsm = arir_pkg::ARIR_RECLAIM;
                    next_st.t_rc = st.reclaim;
                    // counter sticks at full scale rather than wrapping to zero
                    if (st.reclose_cnt != 16'hFFFF) begin
                        next_st.reclose_cnt = st.reclose_cnt + 16'h1;
                    end
                    next_st.clear_pend = st.ctrl[`ARIR_CTRL_SIGRST];
                end else if (trip) begin
                    next_st.fsm = arir_pkg::ARIR_LOCKOUT;
                end
            end
            arir_pkg::ARIR_RECLAIM: begin
                if (tripped) begin
                    if (st.shot >= `ARIR_MAX_SHOTS) begin
                        next_st.fsm = arir_pkg::ARIR_LOCKOUT;
                    end else begin
                        next_st.fsm = arir_pkg::ARIR_DEAD;
                        next_st.shot = st.shot + 3'h1;
                    end
                end else if (st.t_rc == 16'h0 && contact) begin
                    // staying closed to reclaim end means success
                    next_st.fsm = arir_pkg::ARIR_IDLE;
                    next_st.success = 1'b1;
                    next_st.shot = 3'h0;
                end
            end
            arir_pkg::ARIR_LOCKOUT: begin
                // only software leaves lockout; signal clearing never does
                if (lock_clr) begin
                    next_st.fsm = arir_pkg::ARIR_IDLE;
                    next_st.shot = 3'h0;
                end
            end
            default: begin
                next_st.fsm = arir_pkg::ARIR_IDLE;
            end
        endcase

        // entering dead time reloads the dead, drop-off and energy window timers
        if (next_st.fsm == arir_pkg::ARIR_DEAD && st.fsm != arir_pkg::ARIR_DEAD) begin
            next_st.t_dead = st.dead;
            next_st.t_drop = st.neutral_cycle ? st.drop_ne : st.drop_ph;
            next_st.t_en = st.energy_win;
            next_st.dead_done = 1'b0;
            next_st.drop_done = 1'b0;
        end

        // ack one cycle after the take, then low even if strobe stays up
        next_st.ack = bus_req;
        if (bus_wr) begin
            case (i_wb_adr[5:2])
                `ARIR_REG_CTRL: begin
                    if (i_wb_sel[0]) begin
                        next_st.ctrl = i_wb_dat[7:0];
                    end
                end
                `ARIR_REG_DEAD: next_st.dead = arir_wr(st.dead, i_wb_dat, i_wb_sel);
                `ARIR_REG_DROP: begin
                    next_st.drop_ph = arir_wr(st.drop_ph, i_wb_dat, i_wb_sel);
                    next_st.drop_ne = arir_wr(st.drop_ne, i_wb_dat >> 16,
                                              {2'b00, i_wb_sel[3:2]});
                end
                `ARIR_REG_RECLAIM: next_st.reclaim = arir_wr(st.reclaim, i_wb_dat, i_wb_sel);
                `ARIR_REG_ENERGY: begin
                    next_st.energy_win = arir_wr(st.energy_win, i_wb_dat, i_wb_sel);
                end
                default: begin
                end
            endcase
        end
        // read mux runs every cycle; data only matters alongside ack
        case (i_wb_adr[5:2])
            `ARIR_REG_CTRL:    next_st.rdat = {24'h0, st.ctrl};
            `ARIR_REG_DEAD:    next_st.rdat = {16'h0, st.dead};
            `ARIR_REG_DROP:    next_st.rdat = {st.drop_ne, st.drop_ph};
            `ARIR_REG_RECLAIM: next_st.rdat = {16'h0, st.reclaim};
            `ARIR_REG_ENERGY:  next_st.rdat = {16'h0, st.energy_win};
            `ARIR_REG_STATUS:  next_st.rdat = {22'h0, st.fsm, st.shot, st.success,
                                               st.lout, st.ind[0], contact};
            `ARIR_REG_SHOTS:   next_st.rdat = {16'h0, st.reclose_cnt};
            default:           next_st.rdat = 32'h0;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st <= '0;
            // protection idle level is reset; starting there avoids a false trip edge
            st.prst_s <= 2'b11;
            st.prst_d <= 1'b1;
            st.ctrl <= `ARIR_CTRL_RESET;
            st.dead <= `ARIR_DEAD_RESET;
            st.drop_ph <= `ARIR_DROP_RESET;
            st.drop_ne <= `ARIR_DROP_RESET;
            st.reclaim <= `ARIR_RECLAIM_RESET;
            st.energy_win <= `ARIR_ENERGY_RESET;
            st.fsm <= arir_pkg::ARIR_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign o_wb_dat         = st.rdat;
    assign o_wb_ack         = st.ack;
    assign o_close_cmd      = st.close_cmd;
    assign o_indication     = st.ind;
    assign o_latched_output = st.lout;
    assign o_in_progress    = st.fsm != arir_pkg::ARIR_IDLE
                              && st.fsm != arir_pkg::ARIR_LOCKOUT;
    assign o_lockout        = st.fsm == arir_pkg::ARIR_LOCKOUT;
    assign o_success        = st.success;
endmodule : arir_core

/* File: verilog/arir_params.svh */
/*
 auto-reclose indication reset: register offsets, field positions, reset values, timing.
 assumes inclusion by bare name from the design and bench files.
*/
`ifndef ARIR_PARAMS_SVH
`define ARIR_PARAMS_SVH

`define ARIR_REG_CTRL      4'h0
`define ARIR_REG_DEAD      4'h1
`define ARIR_REG_DROP      4'h2
`define ARIR_REG_RECLAIM   4'h3
`define ARIR_REG_ENERGY    4'h4
`define ARIR_REG_STATUS    4'h5
`define ARIR_REG_CMD       4'h6
`define ARIR_REG_SHOTS     4'h7

`define ARIR_CTRL_ENABLE   0
`define ARIR_CTRL_SIGRST   1
`define ARIR_CTRL_LAMPPOL  2
`define ARIR_CTRL_OUTPOL   3
`define ARIR_CTRL_STARTSRC 4
`define ARIR_CTRL_RCBLOCK  5
`define ARIR_CTRL_INVCURVE 6
`define ARIR_CTRL_DELAYED  7
`define ARIR_CTRL_RESET    8'h01

`define ARIR_CMD_GENRESET  0
`define ARIR_CMD_LOCKCLR   1

`define ARIR_TICK_MS       1
`define ARIR_CLK_MHZ       100
`define ARIR_TICK_CYCLES   (`ARIR_TICK_MS * `ARIR_CLK_MHZ * 1000)
`define ARIR_DEAD_RESET    16'h03E8
`define ARIR_DROP_RESET    16'h0000
`define ARIR_RECLAIM_RESET 16'h1388
`define ARIR_ENERGY_RESET  16'h01F4
`define ARIR_MAX_SHOTS     3'h4

`endif

/* File: verilog/arir_pkg.sv */
/*
 types shared by the auto-reclose indication reset block.
 assumes arir_params.svh is on the include path.
*/
package arir_pkg;
    typedef enum logic [2:0] {
        ARIR_IDLE    = 3'b000,
        ARIR_DEAD    = 3'b001,
        ARIR_CLOSE   = 3'b010,
        ARIR_RECLAIM = 3'b011,
        ARIR_LOCKOUT = 3'b100
    } arir_state_t;
endpackage : arir_pkg

/* File: verilog/arir_tick.sv */
/*
 divider making a one-cycle millisecond enable from i_clk.
 assumes 100 MHz clock and synchronous active-high reset.
*/
`timescale 1ns/1ns
`include "arir_params.svh"
module arir_tick #(
    parameter int TICK_CYCLES = `ARIR_TICK_CYCLES
) (
    input  wire logic i_clk,
    input  wire logic i_rst,
    output logic      o_tick
);
    typedef struct packed {
        logic [31:0] cnt;
        logic        tick;
    } arir_tick_st_t;

    arir_tick_st_t st;
    arir_tick_st_t next_st;

    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (st.cnt >= 32'(TICK_CYCLES - 1)) begin
            next_st.cnt = 32'h0;
            next_st.tick = 1'b1;
        end else begin
            next_st.cnt = st.cnt + 32'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_tick = st.tick;
endmodule : arir_tick

/* File: sim/arir_core_assertions.sv */
/*
 checker for arir_core port behaviour.
 assumes binding onto arir_core; one clock, sync active-high reset.
*/
`timescale 1ns/1ns
module arir_core_assertions #(
    parameter int TICK_CYCLES = 10
) (
    input wire logic       i_clk,
    input wire logic       i_rst,
    input wire logic       i_wb_cyc,
    input wire logic       i_wb_stb,
    input wire logic       i_wb_we,
    input wire logic       i_new_trip_latch,
    input wire logic       i_operator_reset,
    input wire logic       o_wb_ack,
    input wire logic       o_close_cmd,
    input wire logic [3:0] o_indication,
    input wire logic       o_latched_output,
    input wire logic       o_in_progress,
    input wire logic       o_lockout,
    input wire logic       o_success
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    chk_ack_once:
        assert property ((i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack)
        else $error("bus request not answered next cycle");
    chk_ack_drop:
        assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack held longer than one cycle");
    chk_close_pulse:
        assert property (o_close_cmd |=> !o_close_cmd)
        else $error("close command wider than one cycle");
    chk_close_in_seq:
        assert property (o_close_cmd |-> $past(o_in_progress) && o_in_progress)
        else $error("close command outside a reclose sequence");
    chk_lock_quiet:
        assert property (o_lockout |-> !o_in_progress && !o_close_cmd)
        else $error("lockout with sequence activity");
    chk_lock_hold:
        assert property ($fell(o_lockout) |-> $past(i_wb_we && i_wb_stb))
        else $error("lockout left without a bus write");
    chk_success_idle:
        assert property ($rose(o_success) |-> !o_in_progress && !o_lockout)
        else $error("success raised while sequence busy");
    chk_gen_reset:
        assert property ((i_operator_reset && !i_new_trip_latch)[*6]
                         |-> o_indication == 4'h0 && !o_latched_output)
        else $error("general reset did not clear indications");
endmodule : arir_core_assertions

bind arir_core arir_core_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_arir_core_assertions (
    .i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we), .i_new_trip_latch(i_new_trip_latch),
    .i_operator_reset(i_operator_reset), .o_wb_ack(o_wb_ack), .o_close_cmd(o_close_cmd),
    .o_indication(o_indication), .o_latched_output(o_latched_output),
    .o_in_progress(o_in_progress), .o_lockout(o_lockout), .o_success(o_success));

/* File: sim/arir_breaker.sv */
/*
 breaker model: auxiliary contact and close coil.
 assumes pulses sampled on i_clk; contact starts closed.
*/
`timescale 1ns/1ns
module arir_breaker (
    input  wire logic       i_clk,
    input  wire logic       i_close,
    input  wire logic       i_open,
    input  wire logic [7:0] i_delay,
    output logic            o_contact = 1'b1
);
    logic [7:0] cnt = 8'h00;
    // contact opens at once on an open pulse and closes a mechanism delay after a close pulse
    always @(posedge i_clk) begin
        if (i_open) begin
            o_contact <= 1'b0;
            cnt <= 8'h00;
        end else if (i_close) begin
            cnt <= i_delay;
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
            o_contact <= (cnt == 8'h01);
        end
    end
endmodule : arir_breaker

/* File: sim/tb_top.sv */
/*
 self-checking bench for arir_core with a breaker model.
 assumes short tick (10 cycles) and 100 MHz clock.
*/
`timescale 1ns/1ns
`include "arir_params.svh"
module tb_top;
    localparam int T = 10;
    logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
    logic [5:0]  adr = 6'h00;
    logic [31:0] wdat = 32'h0, rdat;
    localparam int P_SPH = 0, P_SNE = 1, P_NTL = 2, P_OPR = 3, P_MAN = 4;
    localparam int W_CLOSE = 0, W_CONTACT = 1, W_SUCC = 2, W_LOCK = 3;
    logic        contact, trip = 1'b0, prst = 1'b1, eok = 1'b1;
    logic        close, lout, inp, lock, succ, brk_open = 1'b0;
    logic [4:0]  pin_pulse = 5'h00;
    logic [3:0]  ind;
    int          failures = 0, total_checks = 0;

    always #5 clk = ~clk;

    arir_core #(.TICK_CYCLES(T)) u_arir_core (
        .i_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_breaker_closed_contact(contact), .i_trip(trip),
        .i_start_phase(pin_pulse[P_SPH]), .i_start_neutral(pin_pulse[P_SNE]),
        .i_prot_reset(prst), .i_energy_ok(eok), .i_new_trip_latch(pin_pulse[P_NTL]),
        .i_operator_reset(pin_pulse[P_OPR]), .o_close_cmd(close),
        .o_indication(ind), .o_latched_output(lout), .o_in_progress(inp),
        .o_lockout(lock), .o_success(succ));
    arir_breaker u_arir_breaker (.i_clk(clk), .i_close(close | pin_pulse[P_MAN]),
        .i_open(brk_open),
        .i_delay(8'h05), .o_contact(contact));

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [3:0] ix, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {ix, 2'b00};
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        if (n >= 50) chk("bus answer", 1, 0);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb

    task automatic wr(input logic [3:0] ix, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, ix, d, q);
    endtask : wr

    task automatic rd(input string nm, input logic [3:0] ix, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, ix, 32'h0, q);
        chk(nm, e, q);
    endtask : rd

    task automatic pulse(input int k, input int n);
        pin_pulse[k] <= 1'b1;
        repeat (n) @(posedge clk);
        pin_pulse[k] <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : pulse

    function automatic logic watched(input int k);
        case (k)
            W_CLOSE:   watched = close;
            W_CONTACT: watched = contact;
            W_SUCC:    watched = succ;
            default:   watched = lock;
        endcase
    endfunction : watched

    task automatic wait_for(input int k, input int lim, output int n);
        n = 0;
        while (watched(k) !== 1'b1 && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask : wait_for

    task automatic open_brk;
        brk_open <= 1'b1;
        trip <= 1'b1;
        @(posedge clk);
        brk_open <= 1'b0;
        trip <= 1'b0;
    endtask : open_brk

    task automatic t_regs;
        logic [3:0]  ix [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8};
        logic [31:0] ex [7] = '{32'(`ARIR_CTRL_RESET), 32'(`ARIR_DEAD_RESET),
                                32'(`ARIR_DROP_RESET), 32'(`ARIR_RECLAIM_RESET),
                                32'(`ARIR_ENERGY_RESET), 32'h0, 32'h0};
        wr(4'h7, 32'hFF);
        wr(4'h8, 32'hFF);
        foreach (ix[i]) rd("reset value", ix[i], ex[i]);
        $display("test regs done");
    endtask : t_regs

    // close must land at the later of dead time and drop-off
    task automatic t_shot(input int d, input logic [31:0] dp, input logic neu, input int m);
        int n;
        wr(`ARIR_REG_DEAD, d);
        wr(`ARIR_REG_DROP, dp);
        pulse(neu ? P_SNE : P_SPH, 4);
        pulse(P_NTL, 4);
        chk("indication set", 32'hF, 32'(ind));
        open_brk();
        wait_for(W_CLOSE, 300, n);
        chk("close timing", 1, 32'(n >= (m - 1) * T && n <= (m + 2) * T));
        wait_for(W_CONTACT, 50, n);
        chk("contact closed", 32'h1, 32'(contact));
        repeat (5) @(posedge clk);
        chk("cleared on close", 32'h0, {27'h0, ind, lout});
        chk("reclaim running", 1, 32'(inp));
        wait_for(W_SUCC, 300, n);
        chk("success", 1, 32'(succ));
        $display("test shot done");
    endtask : t_shot

    task automatic t_lock;
        int n;
        wr(`ARIR_REG_CTRL, 32'h93);
        wr(`ARIR_REG_DEAD, 32'h2);
        wr(`ARIR_REG_DROP, 32'h0);
        wr(`ARIR_REG_ENERGY, 32'h3);
        eok <= 1'b0;
        open_brk();
        wait_for(W_LOCK, 300, n);
        chk("lockout timing", 1, 32'(n >= 4 * T && n <= 8 * T));
        chk("no close in lockout", 32'h0, 32'(close));
        eok <= 1'b1;
        wr(`ARIR_REG_CMD, 32'h2);
        chk("lockout cleared", 32'h0, 32'(lock));
        pulse(P_MAN, 1);
        wait_for(W_CONTACT, 50, n);
        chk("manual close", 32'h1, 32'(contact));
        $display("test lockout done");
    endtask : t_lock

    task automatic t_genrst;
        wr(`ARIR_REG_CTRL, 32'h01);
        pulse(P_NTL, 4);
        pulse(P_OPR, 8);
        chk("operator reset", 32'h0, {27'h0, ind, lout});
        pulse(P_NTL, 4);
        wr(`ARIR_REG_CMD, 32'h1);
        repeat (4) @(posedge clk);
        chk("command reset", 32'h0, {27'h0, ind, lout});
        $display("test general reset done");
    endtask : t_genrst

    task automatic t_pol;
        logic [31:0] c [3] = '{32'h01, 32'h05, 32'h09};
        logic [4:0]  e [3] = '{5'h1F, 5'h01, 5'h1E};
        foreach (c[i]) begin
            wr(`ARIR_REG_CTRL, c[i]);
            pulse(P_NTL, 4);
            pulse(P_SPH, 4);
            chk("policy clear", 32'(e[i]), {27'h0, ind, lout});
            pulse(P_OPR, 8);
        end
        $display("test policy done");
    endtask : t_pol

    // a start held through reclaim keeps the reclaim timer from running out
    task automatic t_block;
        int n;
        wr(`ARIR_REG_CTRL, 32'h33);
        pulse(P_NTL, 4);
        open_brk();
        wait_for(W_CLOSE, 300, n);
        pin_pulse[P_SPH] <= 1'b1;
        repeat (60) @(posedge clk);
        chk("reclaim held", 32'h1, 32'(inp));
        pin_pulse[P_SPH] <= 1'b0;
        wait_for(W_SUCC, 300, n);
        chk("reclaim ends", 32'h1, 32'(succ));
        $display("test reclaim block done");
    endtask : t_block

    task automatic finish_test;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        wr(`ARIR_REG_CTRL, 32'h13);
        wr(`ARIR_REG_RECLAIM, 32'h2);
        t_shot(6'd2, {16'h0, 16'h6}, 1'b0, 6);
        t_shot(6'd6, {16'h0, 16'h2}, 1'b0, 6);
        t_shot(6'd2, {16'h6, 16'h1}, 1'b1, 6);
        rd("reclose count", `ARIR_REG_SHOTS, 32'h3);
        t_block();
        t_lock();
        t_genrst();
        t_pol();
        finish_test();
    end

    // whole run needs roughly a thousand cycles
    initial begin
        #200000;
        failures++;
        $display("watchdog expired");
        finish_test();
    end
endmodule : tb_top
